// File: verilog/spi_evt_params.svh
// constants for the event, dma request and idle control blocks
// assumes: word-indexed register port, one clock for both ends
`ifndef SPI_EVT_PARAMS_SVH
`define SPI_EVT_PARAMS_SVH
`define CHANNELS 4
`define DATA_W 32
`define ADDR_W 8
// device register word indices
`define A_EVT_STATUS_LOW 8'h00
`define A_EVT_ENABLE_LOW 8'h01
`define A_SYS_CONFIG_LOW 8'h02
`define A_SYS_STATUS_LOW 8'h03
`define A_CHAN_CTRL 8'h04
`define A_CHAN_CFG_BASE 8'h08
`define A_TX_BASE 8'h10
`define A_RX_BASE 8'h18
// event bit offsets inside each channel nibble
`define EV_PER_CH 4
`define EV_TX_EMPTY 0
`define EV_TX_UNDERFLOW 1
`define EV_RX_FULL 2
`define EV_RX_OVERFLOW 3
// field positions
`define CFG_DMA_RD_BIT 15
`define CFG_DMA_WR_BIT 14
`define SC_AUTOGATE_BIT 0
`define SC_SOFTRESET_BIT 1
`define SC_IDLE_LSB 3
`define SC_KEEP_LSB 8
`define CC_MASTER_BIT 8
`define RESET_CYCLES 4'h4
// idle handshake codes
`define IDLE_FORCE 2'h0
`define IDLE_NONE 2'h1
`define IDLE_SMART 2'h2
// controller register word indices
`define H_CTRL 8'h00
`define H_STATUS 8'h01
`define H_DMA_COUNT 8'h02
`define H_DMA_WDATA 8'h03
`define H_DMA_RDATA 8'h04
`define HC_IDLE_REQ_BIT 0
`define HC_BRIDGE_STOP_BIT 1
`define HC_FUNC_STOP_BIT 2
`define HC_DMA_AUTO_BIT 3
`endif

// File: verilog/spi_evt_pkg.sv
// shared types for the event, dma request and idle control blocks
// assumes: spi_evt_params.svh gives the numbers
package spi_evt_pkg;
    typedef logic [1:0] idle_mode_t;
    typedef enum logic [1:0] {PH_RUN, PH_WAIT_ACK, PH_IDLE, PH_WAKE} idle_phase_t;
endpackage : spi_evt_pkg

// File: verilog/spi_evt_if.sv
// link between the spi event block and the system dma / clock-stop logic
// assumes: both ends share clk_sys_i
`include "spi_evt_params.svh"
interface spi_evt_if #(
    parameter int N = `CHANNELS,
    parameter int W = `DATA_W
);
    logic [N-1:0] dma_rd_req;
    logic [N-1:0] dma_wr_req;
    logic dma_rd_done;
    logic dma_wr_done;
    logic [$clog2(N)-1:0] dma_ch;
    logic [W-1:0] dma_wr_data;
    logic [W-1:0] dma_rd_data;
    logic idle_req;
    logic idle_ack;
    logic bridge_stop_req;
    logic func_stop_req;
    logic bridge_clk_off;
    logic func_clk_off;
    logic clk_present;
    modport device (
        output dma_rd_req, dma_wr_req, dma_rd_data, idle_ack, bridge_clk_off, func_clk_off,
        input dma_rd_done, dma_wr_done, dma_ch, dma_wr_data, idle_req, bridge_stop_req,
        input func_stop_req, clk_present
    );
    modport system (
        input dma_rd_req, dma_wr_req, dma_rd_data, idle_ack, bridge_clk_off, func_clk_off,
        output dma_rd_done, dma_wr_done, dma_ch, dma_wr_data, idle_req, bridge_stop_req,
        output func_stop_req, clk_present
    );
endinterface : spi_evt_if

// File: verilog/spi_event_dma_idle_control.sv
// event status, dma request and idle handshake logic of a multichannel spi block
// assumes: shifter strobes and register port run on clk_sys_i; chip select is a pin
`include "spi_evt_params.svh"
module spi_event_dma_idle_control #(
    parameter int N = `CHANNELS,
    parameter int W = `DATA_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [W-1:0] rdata_o,
    input wire logic [N-1:0] rx_word_valid_i,
    input wire logic [N*W-1:0] rx_word_i,
    input wire logic [N-1:0] tx_take_i,
    output logic [N*W-1:0] tx_word_o,
    output logic [N-1:0] chan_enable_o,
    output logic master_mode_o,
    input wire logic cs_pin_i,
    output logic irq_o,
    output logic autogate_o,
    spi_evt_if.device link
);
    import spi_evt_pkg::*;

    localparam int NE = N * `EV_PER_CH;

    typedef struct packed {
        logic [N-1:0][W-1:0] rx_data;
        logic [N-1:0][W-1:0] tx_data;
        logic [N-1:0] rx_full;
        logic [N-1:0] tx_empty;
        logic [N-1:0] tx_loaded;
        logic [N-1:0] ch_en;
        logic [N-1:0] dma_read_request_enable_en;
        logic [N-1:0] dma_write_request_enable_en;
        logic [NE-1:0] status;
        logic [NE-1:0] enable;
        logic auto_gate;
        idle_mode_t idle_mode;
        logic [1:0] keepalive;
        logic master;
        logic [2:0] cs_sync;
        logic cs_act;
        logic mask_hold;
        logic [3:0] rst_cnt;
        logic rst_done;
        logic [W-1:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic forced;
    logic lines_off;
    logic quiet;

    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.auto_gate = 1'b1;
        r.idle_mode = `IDLE_NONE;
        r.rst_cnt = `RESET_CYCLES;
        return r;
    endfunction : reset_state

    function automatic int ev_bit(input int ch, input int ev);
        return ch * `EV_PER_CH + ev;
    endfunction : ev_bit

    // force idle masks the lines and holds them one more cycle after wake
    assign forced = (s_reg.idle_mode == `IDLE_FORCE) && link.idle_req;
    assign lines_off = forced || s_reg.mask_hold;
    assign quiet = !(|(s_reg.ch_en & (s_reg.rx_full | ~s_reg.tx_empty)))
        && !(wr_i || rd_i) && (s_reg.master || !s_reg.cs_act);

    always_comb begin
        logic [NE-1:0] ev;
        logic [NE-1:0] clr;
        logic [N-1:0] en_new;
        int c;
        s_next = s_reg;
        ev = '0;
        clr = '0;
        en_new = s_reg.ch_en;
        c = 0;
        s_next.rdata = '0;
        s_next.mask_hold = forced;
        s_next.cs_sync = {s_reg.cs_sync[1:0], cs_pin_i};
        if (s_reg.cs_sync[2] == s_reg.cs_sync[1]) begin
            s_next.cs_act = s_reg.cs_sync[2];
        end
        if (!s_reg.rst_done) begin
            if (s_reg.rst_cnt == 4'h0) begin
                s_next.rst_done = 1'b1;
            end else if (link.clk_present) begin
                s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
            end
        end
        if (wr_i) begin
            if (addr_i == `A_EVT_STATUS_LOW) begin
                clr = wdata_i[NE-1:0];
            end else if (addr_i == `A_EVT_ENABLE_LOW) begin
                s_next.enable = wdata_i[NE-1:0];
            end else if (addr_i == `A_SYS_CONFIG_LOW) begin
                s_next.auto_gate = wdata_i[`SC_AUTOGATE_BIT];
                s_next.idle_mode = wdata_i[`SC_IDLE_LSB +: 2];
                s_next.keepalive = wdata_i[`SC_KEEP_LSB +: 2];
            end else if (addr_i == `A_CHAN_CTRL) begin
                en_new = wdata_i[N-1:0];
                s_next.master = wdata_i[`CC_MASTER_BIT];
            end
        end
        for (c = 0; c < N; c++) begin
            if (wr_i && addr_i == `A_CHAN_CFG_BASE + c[`ADDR_W-1:0]) begin
                s_next.dma_read_request_enable_en[c] = wdata_i[`CFG_DMA_RD_BIT];
                s_next.dma_write_request_enable_en[c] = wdata_i[`CFG_DMA_WR_BIT];
            end
            if (wr_i && addr_i == `A_TX_BASE + c[`ADDR_W-1:0]) begin
                s_next.tx_data[c] = wdata_i;
                s_next.tx_empty[c] = 1'b0;
                s_next.tx_loaded[c] = 1'b1;
            end
            if (rd_i && addr_i == `A_RX_BASE + c[`ADDR_W-1:0]) begin
                s_next.rx_full[c] = 1'b0;
            end
            if (link.dma_rd_done && link.dma_ch == c[$clog2(N)-1:0]) begin
                s_next.rx_full[c] = 1'b0;
            end
            if (link.dma_wr_done && link.dma_ch == c[$clog2(N)-1:0]) begin
                s_next.tx_data[c] = link.dma_wr_data;
                s_next.tx_empty[c] = 1'b0;
                s_next.tx_loaded[c] = 1'b1;
            end
            // each channel raises its own events independently
            if (en_new[c] && !s_reg.ch_en[c]) begin
                s_next.tx_empty[c] = 1'b1;
                s_next.tx_loaded[c] = 1'b0;
                ev[ev_bit(c, `EV_TX_EMPTY)] = 1'b1;
            end
            if (s_reg.ch_en[c] && tx_take_i[c]) begin
                if (s_reg.tx_empty[c]) begin
                    ev[ev_bit(c, `EV_TX_UNDERFLOW)] = s_reg.tx_loaded[c];
                end else begin
                    s_next.tx_empty[c] = 1'b1;
                    ev[ev_bit(c, `EV_TX_EMPTY)] = 1'b1;
                end
            end
            if (s_reg.ch_en[c] && rx_word_valid_i[c]) begin
                ev[ev_bit(c, `EV_RX_OVERFLOW)] = s_reg.rx_full[c];
                ev[ev_bit(c, `EV_RX_FULL)] = 1'b1;
                s_next.rx_data[c] = rx_word_i[c*W +: W];
                s_next.rx_full[c] = 1'b1;
            end
        end
        s_next.ch_en = en_new;
        // the set wins over a clear in the same cycle; idle entry leaves bits alone
        s_next.status = (s_reg.status & ~clr) | ev;
        if (rd_i) begin
            if (addr_i == `A_EVT_STATUS_LOW) begin
                s_next.rdata[NE-1:0] = s_reg.status;
            end else if (addr_i == `A_EVT_ENABLE_LOW) begin
                s_next.rdata[NE-1:0] = s_reg.enable;
            end else if (addr_i == `A_SYS_CONFIG_LOW) begin
                s_next.rdata[`SC_AUTOGATE_BIT] = s_reg.auto_gate;
                s_next.rdata[`SC_IDLE_LSB +: 2] = s_reg.idle_mode;
                s_next.rdata[`SC_KEEP_LSB +: 2] = s_reg.keepalive;
            end else if (addr_i == `A_SYS_STATUS_LOW) begin
                s_next.rdata[0] = s_reg.rst_done;
            end else if (addr_i == `A_CHAN_CTRL) begin
                s_next.rdata[N-1:0] = s_reg.ch_en;
                s_next.rdata[`CC_MASTER_BIT] = s_reg.master;
            end
            for (c = 0; c < N; c++) begin
                if (addr_i == `A_CHAN_CFG_BASE + c[`ADDR_W-1:0]) begin
                    s_next.rdata[`CFG_DMA_RD_BIT] = s_reg.dma_read_request_enable_en[c];
                    s_next.rdata[`CFG_DMA_WR_BIT] = s_reg.dma_write_request_enable_en[c];
                end
                if (addr_i == `A_TX_BASE + c[`ADDR_W-1:0]) begin
                    s_next.rdata = s_reg.tx_data[c];
                end
                if (addr_i == `A_RX_BASE + c[`ADDR_W-1:0]) begin
                    s_next.rdata = s_reg.rx_data[c];
                end
            end
        end
        // a soft reset restarts everything and lets reset-done rise again
        if (wr_i && addr_i == `A_SYS_CONFIG_LOW && wdata_i[`SC_SOFTRESET_BIT]) begin
            s_next = reset_state();
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_reg <= reset_state();
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        link.idle_ack = 1'b0;
        unique case (s_reg.idle_mode)
            `IDLE_NONE: link.idle_ack = 1'b0;
            `IDLE_FORCE: link.idle_ack = link.idle_req;
            `IDLE_SMART: link.idle_ack = link.idle_req && quiet;
            default: link.idle_ack = 1'b0;
        endcase
    end

    assign link.bridge_clk_off = link.idle_ack && (forced
        || (link.bridge_stop_req && s_reg.keepalive[0]));
    assign link.func_clk_off = link.idle_ack && (forced
        || (link.func_stop_req && s_reg.keepalive[1]));
    assign link.dma_rd_req = s_reg.ch_en & s_reg.rx_full & s_reg.dma_read_request_enable_en
        & {N{!lines_off}};
    assign link.dma_wr_req = s_reg.ch_en & s_reg.tx_empty & s_reg.dma_write_request_enable_en
        & {N{!lines_off}};
    assign link.dma_rd_data = s_reg.rx_data[link.dma_ch];
    assign irq_o = (|(s_reg.status & s_reg.enable)) && !lines_off;
    assign autogate_o = s_reg.auto_gate && quiet;
    assign rdata_o = s_reg.rdata;
    assign tx_word_o = s_reg.tx_data;
    assign chan_enable_o = s_reg.ch_en;
    assign master_mode_o = s_reg.master;
endmodule : spi_event_dma_idle_control

// File: verilog/clock_stop_dma_ctrl.sv
// system side: clock-stop request/acknowledge and a simple dma servicing engine
// assumes: shares clk_sys_i with the device; software drives the plain register port
`include "spi_evt_params.svh"
module clock_stop_dma_ctrl #(
    parameter int N = `CHANNELS,
    parameter int W = `DATA_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [W-1:0] rdata_o,
    input wire logic clk_present_i,
    spi_evt_if.system link
);
    import spi_evt_pkg::*;

    typedef struct packed {
        logic idle_req;
        logic bridge_stop;
        logic func_stop;
        logic dma_auto;
        idle_phase_t phase;
        logic rd_done;
        logic wr_done;
        logic [$clog2(N)-1:0] ch;
        logic [15:0] dma_count;
        logic [W-1:0] dma_wdata;
        logic [W-1:0] dma_rdata;
        logic [W-1:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic [$clog2(N)-1:0] lowest(input logic [N-1:0] v);
        logic [$clog2(N)-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[$clog2(N)-1:0];
            end
        end
        return r;
    endfunction : lowest

    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.rd_done = 1'b0;
        s_next.wr_done = 1'b0;
        if (wr_i && addr_i == `H_CTRL) begin
            s_next.idle_req = wdata_i[`HC_IDLE_REQ_BIT];
            s_next.bridge_stop = wdata_i[`HC_BRIDGE_STOP_BIT];
            s_next.func_stop = wdata_i[`HC_FUNC_STOP_BIT];
            s_next.dma_auto = wdata_i[`HC_DMA_AUTO_BIT];
        end
        if (wr_i && addr_i == `H_DMA_WDATA) begin
            s_next.dma_wdata = wdata_i;
        end
        if (wr_i && addr_i == `H_DMA_COUNT) begin
            s_next.dma_count = '0;
        end
        unique case (s_reg.phase)
            PH_RUN: if (s_reg.idle_req) s_next.phase = PH_WAIT_ACK;
            PH_WAIT_ACK: begin
                if (!s_reg.idle_req) begin
                    s_next.phase = PH_RUN;
                end else if (link.idle_ack) begin
                    s_next.phase = PH_IDLE;
                end
            end
            PH_IDLE: if (!s_reg.idle_req) s_next.phase = PH_WAKE;
            PH_WAKE: if (!link.idle_ack) s_next.phase = PH_RUN;
        endcase
        // one transfer at a time; the gap cycle lets the request line fall
        if (s_reg.rd_done) begin
            s_next.dma_rdata = link.dma_rd_data;
        end
        if (s_reg.dma_auto && s_reg.phase == PH_RUN && !s_reg.rd_done && !s_reg.wr_done) begin
            if (|link.dma_rd_req) begin
                s_next.rd_done = 1'b1;
                s_next.ch = lowest(link.dma_rd_req);
                s_next.dma_count = s_reg.dma_count + 16'h1;
            end else if (|link.dma_wr_req) begin
                s_next.wr_done = 1'b1;
                s_next.ch = lowest(link.dma_wr_req);
                s_next.dma_count = s_reg.dma_count + 16'h1;
            end
        end
        if (rd_i) begin
            if (addr_i == `H_CTRL) begin
                s_next.rdata[`HC_IDLE_REQ_BIT] = s_reg.idle_req;
                s_next.rdata[`HC_BRIDGE_STOP_BIT] = s_reg.bridge_stop;
                s_next.rdata[`HC_FUNC_STOP_BIT] = s_reg.func_stop;
                s_next.rdata[`HC_DMA_AUTO_BIT] = s_reg.dma_auto;
            end else if (addr_i == `H_STATUS) begin
                s_next.rdata[0] = link.idle_ack;
                s_next.rdata[1] = link.bridge_clk_off;
                s_next.rdata[2] = link.func_clk_off;
                s_next.rdata[5:4] = s_reg.phase;
                s_next.rdata[8 +: N] = link.dma_rd_req;
                s_next.rdata[16 +: N] = link.dma_wr_req;
            end else if (addr_i == `H_DMA_COUNT) begin
                s_next.rdata[15:0] = s_reg.dma_count;
            end else if (addr_i == `H_DMA_WDATA) begin
                s_next.rdata = s_reg.dma_wdata;
            end else if (addr_i == `H_DMA_RDATA) begin
                s_next.rdata = s_reg.dma_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.idle_req = s_reg.idle_req;
    assign link.bridge_stop_req = s_reg.bridge_stop;
    assign link.func_stop_req = s_reg.func_stop;
    assign link.dma_rd_done = s_reg.rd_done;
    assign link.dma_wr_done = s_reg.wr_done;
    assign link.dma_ch = s_reg.ch;
    assign link.dma_wr_data = s_reg.dma_wdata;
    assign link.clk_present = clk_present_i;
    assign rdata_o = s_reg.rdata;
endmodule : clock_stop_dma_ctrl

// File: dv/spi_evt_assertions.sv
// concurrent checks on the link between the spi event block and the system side
// assumes: one clock for both ends; instantiated by the bench beside the link
`include "spi_evt_params.svh"
module spi_evt_assertions #(
    parameter int N = `CHANNELS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [N-1:0] dma_rd_req,
    input wire logic [N-1:0] dma_wr_req,
    input wire logic dma_rd_done,
    input wire logic dma_wr_done,
    input wire logic [$clog2(N)-1:0] dma_ch,
    input wire logic idle_req,
    input wire logic idle_ack,
    input wire logic bridge_stop_req,
    input wire logic bridge_clk_off,
    input wire logic func_clk_off
);
    timeunit 1ns;
    timeprecision 100ps;
    import spi_evt_pkg::*;
    logic [N-1:0] prev_rd_reg;
    logic [N-1:0] prev_wr_reg;
    always_ff @(posedge clk_sys_i) begin
        prev_rd_reg <= rst_i ? '0 : dma_rd_req;
        prev_wr_reg <= rst_i ? '0 : dma_wr_req;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // force idle acknowledged: no stop request yet bridge clock off
    sequence forced_idle_s;
        idle_ack && bridge_clk_off && !bridge_stop_req;
    endsequence
    a_rd_req_drop: assert property (dma_rd_done |=> !dma_rd_req[$past(dma_ch)])
        else $error("read request still up after its dma read");
    a_wr_req_drop: assert property (dma_wr_done |=> !dma_wr_req[$past(dma_ch)])
        else $error("write request still up after its dma load");
    a_rd_done_cause: assert property (dma_rd_done |-> prev_rd_reg[dma_ch])
        else $error("dma read done without a read request");
    a_wr_done_cause: assert property (dma_wr_done |-> prev_wr_reg[dma_ch])
        else $error("dma write done without a write request");
    a_ack_needs_req: assert property (idle_ack |-> idle_req)
        else $error("idle acknowledge without idle request");
    a_bridge_off_ack: assert property (bridge_clk_off |-> idle_ack)
        else $error("bridge clock off without acknowledge");
    a_func_off_ack: assert property (func_clk_off |-> idle_ack)
        else $error("functional clock off without acknowledge");
    a_force_quiet: assert property (forced_idle_s |-> dma_rd_req == '0 && dma_wr_req == '0)
        else $error("dma request up during force idle");
    a_force_both_off: assert property (forced_idle_s |-> func_clk_off)
        else $error("force idle left functional clock on");
    a_wake_delay: assert property (forced_idle_s ##1 !idle_req |-> dma_wr_req == '0)
        else $error("dma request back in the same cycle as wake");
endmodule : spi_evt_assertions

// File: dv/spi_event_dma_idle_control_tb.sv
// bench: device and system ends joined by the link, driven through their register ports
// assumes: shared 200 MHz clock; shifter strobes and chip select driven here
`include "spi_evt_params.svh"
module spi_event_dma_idle_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import spi_evt_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] d_addr = 8'h00, c_addr = 8'h00;
    logic [31:0] d_wdata = 32'h0, c_wdata = 32'h0, d_rdata, c_rdata, rq;
    logic d_wr = 1'b0, d_rd = 1'b0, c_wr = 1'b0, c_rd = 1'b0;
    logic [3:0] rx_valid = 4'h0, tx_take = 4'h0, chan_en;
    logic [127:0] rx_word = 128'h0, tx_word;
    logic cs_pin = 1'b0, clk_present = 1'b0, irq, autogate, master;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] idle_cfg [5] = '{32'h309, 32'h311, 32'h211, 32'h319, 32'h301};
    logic [31:0] idle_ctl [5] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h1};
    logic [31:0] idle_exp [5] = '{32'h0, 32'h3, 32'h1, 32'h0, 32'h7};
    spi_evt_if link_if ();
    spi_event_dma_idle_control u_spi_event_dma_idle_control (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(d_addr), .wdata_i(d_wdata),
        .wr_i(d_wr), .rd_i(d_rd), .rdata_o(d_rdata), .rx_word_valid_i(rx_valid),
        .rx_word_i(rx_word), .tx_take_i(tx_take), .tx_word_o(tx_word), .chan_enable_o(chan_en),
        .master_mode_o(master), .cs_pin_i(cs_pin), .irq_o(irq), .autogate_o(autogate),
        .link(link_if));
    clock_stop_dma_ctrl u_clock_stop_dma_ctrl (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(c_addr), .wdata_i(c_wdata),
        .wr_i(c_wr), .rd_i(c_rd), .rdata_o(c_rdata), .clk_present_i(clk_present), .link(link_if));
    spi_evt_assertions u_spi_evt_assertions (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .dma_rd_req(link_if.dma_rd_req),
        .dma_wr_req(link_if.dma_wr_req), .dma_rd_done(link_if.dma_rd_done),
        .dma_wr_done(link_if.dma_wr_done), .dma_ch(link_if.dma_ch), .idle_req(link_if.idle_req),
        .idle_ack(link_if.idle_ack), .bridge_stop_req(link_if.bridge_stop_req),
        .bridge_clk_off(link_if.bridge_clk_off), .func_clk_off(link_if.func_clk_off));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task give_verdict;
        $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    // one register access on either port; read data sampled in the cycle after the strobe
    task acc(input logic dev, input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        if (dev) begin
            d_addr <= a;
            d_wdata <= d;
            d_wr <= w;
            d_rd <= !w;
        end else begin
            c_addr <= a;
            c_wdata <= d;
            c_wr <= w;
            c_rd <= !w;
        end
        @(posedge clk_sys_i);
        d_wr <= 1'b0;
        d_rd <= 1'b0;
        c_wr <= 1'b0;
        c_rd <= 1'b0;
        #1 rq = dev ? d_rdata : c_rdata;
    endtask : acc
    task rdc(input logic dev, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
             input string what);
        acc(dev, 1'b0, a, 32'h0);
        chk(rq & m, e, what);
    endtask : rdc
    task pulse_rx(input int ch, input logic [31:0] v);
        @(posedge clk_sys_i);
        rx_valid[ch] <= 1'b1;
        rx_word[ch*32 +: 32] <= v;
        @(posedge clk_sys_i);
        rx_valid <= 4'h0;
        #1;
    endtask : pulse_rx
    task pulse_tx(input logic [3:0] m);
        @(posedge clk_sys_i);
        tx_take <= m;
        @(posedge clk_sys_i);
        tx_take <= 4'h0;
        #1;
    endtask : pulse_tx
    // wait, bounded, until the system end has serviced every dma request
    task settle;
        int i;
        for (i = 0; i < 100 && (link_if.dma_rd_req | link_if.dma_wr_req) !== 4'h0; i++)
            @(posedge clk_sys_i);
        if (i == 100) begin
            n_errors++;
            $display("BAD %0t dma service timed out", $time);
            give_verdict();
        end
        #1;
    endtask : settle
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        $display("BAD %0t run timed out", $time);
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(1, `A_SYS_STATUS_LOW, 32'h1, 32'h0, "reset done without clocks");
        rdc(1, `A_SYS_CONFIG_LOW, 32'hffffffff, 32'h9, "config reset value");
        rdc(1, 8'h07, 32'hffffffff, 32'h0, "unmapped read");
        @(posedge clk_sys_i) clk_present <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rdc(1, `A_SYS_STATUS_LOW, 32'h1, 32'h1, "reset done");
        $display("test reset finished");
        acc(1, 1, `A_CHAN_CTRL, 32'h1);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h1, "enable sets tx empty");
        chk({31'h0, irq}, 32'h0, "irq while event disabled");
        acc(1, 1, `A_EVT_STATUS_LOW, 32'h1);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h0, "write one clears");
        acc(1, 1, `A_EVT_ENABLE_LOW, 32'hf);
        acc(1, 1, `A_TX_BASE, 32'hcafe0001);
        pulse_tx(4'h1);
        chk({31'h0, irq}, 32'h1, "irq on enabled event");
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h1, "tx empty after take");
        acc(1, 1, `A_EVT_STATUS_LOW, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        pulse_tx(4'h1);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h2, "underflow");
        acc(1, 1, `A_EVT_STATUS_LOW, 32'h2);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h0, "underflow cleared");
        pulse_rx(0, 32'h11111111);
        pulse_rx(0, 32'h22222222);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'hc, "full and overflow");
        acc(1, 1, `A_EVT_STATUS_LOW, 32'hc);
        rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h0, "rx events cleared");
        $display("test events finished");
        acc(1, 1, `A_CHAN_CTRL, 32'h3);
        chk({28'h0, chan_en}, 32'h3, "channel enables out");
        acc(1, 1, `A_CHAN_CFG_BASE, 32'hc000);
        acc(1, 1, `A_CHAN_CFG_BASE + 8'h1, 32'h4000);
        chk({28'h0, link_if.dma_rd_req}, 32'h1, "read requests");
        chk({28'h0, link_if.dma_wr_req}, 32'h3, "write requests");
        rdc(1, `A_RX_BASE, 32'hffffffff, 32'h22222222, "overwritten word");
        chk({28'h0, link_if.dma_rd_req}, 32'h0, "read request after read");
        acc(0, 1, `H_DMA_WDATA, 32'h12345678);
        acc(0, 1, `H_CTRL, 32'h8);
        settle();
        rdc(0, `H_DMA_COUNT, 32'hffff, 32'h2, "two dma loads");
        acc(0, 1, `H_DMA_COUNT, 32'h0);
        rdc(0, `H_DMA_COUNT, 32'hffff, 32'h0, "dma count cleared");
        rdc(1, `A_TX_BASE + 8'h1, 32'hffffffff, 32'h12345678, "dma loaded word");
        chk(tx_word[63:32], 32'h12345678, "transmit word out");
        pulse_rx(0, 32'h0badf00d);
        settle();
        rdc(0, `H_DMA_RDATA, 32'hffffffff, 32'h0badf00d, "dma read word");
        pulse_rx(1, 32'h5a5a5a5a);
        chk({28'h0, link_if.dma_rd_req}, 32'h0, "masked read request");
        acc(0, 1, `H_CTRL, 32'h0);
        rdc(1, `A_RX_BASE + 8'h1, 32'hffffffff, 32'h5a5a5a5a, "host read ch1");
        $display("test dma finished");
        acc(1, 1, `A_EVT_STATUS_LOW, 32'hffff);
        pulse_tx(4'h3);
        chk({31'h0, autogate}, 32'h1, "autogate when quiet");
        @(posedge clk_sys_i) cs_pin <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #1 chk({31'h0, autogate}, 32'h0, "autogate ends on select");
        @(posedge clk_sys_i) cs_pin <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            acc(1, 1, `A_SYS_CONFIG_LOW, idle_cfg[k]);
            acc(0, 1, `H_CTRL, idle_ctl[k]);
            repeat (3) @(posedge clk_sys_i);
            rdc(0, `H_STATUS, 32'h7, idle_exp[k], "ack and clock stop");
            if (k == 4) begin
                chk({31'h0, irq}, 32'h0, "irq in force idle");
                chk({28'h0, link_if.dma_wr_req}, 32'h0, "dma in force idle");
                rdc(1, `A_EVT_STATUS_LOW, 32'hffff, 32'h11, "status kept in idle");
            end
            acc(0, 1, `H_CTRL, 32'h0);
        end
        repeat (3) @(posedge clk_sys_i);
        #1 chk({31'h0, irq}, 32'h1, "irq back after wake");
        chk({28'h0, link_if.dma_wr_req}, 32'h3, "dma back after wake");
        $display("test idle finished");
        acc(1, 1, `A_SYS_CONFIG_LOW, 32'h2);
        rdc(1, `A_CHAN_CTRL, 32'hffffffff, 32'h0, "soft reset channels");
        rdc(1, `A_SYS_CONFIG_LOW, 32'hffffffff, 32'h9, "soft reset config");
        chk({28'h0, chan_en}, 32'h0, "soft reset enables out");
        acc(1, 1, `A_CHAN_CTRL, 32'h100);
        chk({31'h0, master}, 32'h1, "master after reset");
        @(posedge clk_sys_i) cs_pin <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #1 chk({31'h0, autogate}, 32'h1, "master ignores select");
        @(posedge clk_sys_i) d_rd <= 1'b1;
        #1 chk({31'h0, autogate}, 32'h0, "autogate ends on access");
        @(posedge clk_sys_i) d_rd <= 1'b0;
        $display("test soft reset finished");
        give_verdict();
    end
endmodule : spi_event_dma_idle_control_tb
